//--- rtl/epi_line_detect.v
`timescale 1ns/1ns
`default_nettype none
`include "epi_regs.vh"

module epi_line_detect #(
  parameter EDGE_ONLY = 0
) (
  // Clock, reset, enable
  input wire core_clk,
  input wire rst,
  input wire clk_en,
  // Pin and mode
  input wire pin,
  input wire [1:0] sense,
  // Results
  output wire event_p,
  output wire level_low
);

  reg sync1_q;
  reg sync2_q;
  reg prev_q;
  reg ev;

  // ****************************************
  // Synchroniser and edge detection
  // ****************************************
  always @(posedge core_clk) begin
    if (rst) begin
      sync1_q <= 1'h1;
      sync2_q <= 1'h1;
      prev_q <= 1'h1;
    end else if (clk_en) begin
      sync1_q <= pin; // [RL22] [RL3]
      sync2_q <= sync1_q;
      prev_q <= sync2_q; // [RL20]
    end
  end

  always @* begin
    case (sense)
      `EPI_SENSE_CHANGE: ev = (sync2_q != prev_q); // [RL18]
      `EPI_SENSE_FALL: ev = prev_q & ~sync2_q;
      `EPI_SENSE_RISE: ev = ~prev_q & sync2_q;
      default: ev = 1'h0;
    endcase
  end

  assign event_p = ev;
  assign level_low = (EDGE_ONLY == 0) && (sense == `EPI_SENSE_LOW) && ~sync2_q; // [RL21]

endmodule // epi_line_detect
`default_nettype wire

//--- rtl/epi_regs.vh
// Notes on behaviour
// RL1: Line one enabled by bit 7 and global bit
// RL2: Line one sense from two control bits
// RL3: Pin activity requests even when driven output
// RL4: Each line has its own vector
// RL5: Line zero enabled by bit 6 and global bit
// RL6: Line zero sense from two control bits
// RL7: Line two enabled by bit 5 and global bit
// RL8: Line two edge only, one select bit
// RL9: Line one flag bit 7 set on event
// RL10: Line zero flag bit 6 set on event
// RL11: Line two flag bit 5 set on event
// RL12: Flag, enable and global bit take vector
// RL13: Vector entry clears its flag
// RL14: Writing one clears flag, zero no effect
// RL15: Line one flag zero in level mode
// RL16: Line zero flag zero in level mode
// RL17: Buffer disable in sleep may set flag two
// RL18: Sense 00 low,01 change,10 fall,11 rise
// RL19: Line two select 0 falling, 1 rising
// RL20: Pulses over one clock period are caught
// RL21: Level mode requests while pin stays low
// RL22: Two-stage synchroniser before edge detection
`ifndef EPI_REGS_VH
`define EPI_REGS_VH

// ****************************************
// Register byte addresses
// ****************************************
`define EPI_ADDR_ENABLE 12'h000
`define EPI_ADDR_FLAG 12'h004
`define EPI_ADDR_MCUCTL 12'h008
`define EPI_ADDR_MCUCS 12'h00C
`define EPI_ADDR_CPUSTAT 12'h010
`define EPI_ADDR_ACK 12'h014

// ****************************************
// Field positions
// ****************************************
`define EPI_BIT_LINE_ONE 7
`define EPI_BIT_LINE_ZERO 6
`define EPI_BIT_LINE_TWO 5
`define EPI_BIT_GLOBAL 7
`define EPI_BIT_ONE_SENSE_HI 3
`define EPI_BIT_ONE_SENSE_LO 2
`define EPI_BIT_ZERO_SENSE_HI 1
`define EPI_BIT_ZERO_SENSE_LO 0
`define EPI_BIT_TWO_EDGE 6
`define EPI_BIT_SLEEP_BUF_OFF 0

// ****************************************
// Sense encodings and reset values
// ****************************************
`define EPI_SENSE_LOW 2'h0
`define EPI_SENSE_CHANGE 2'h1
`define EPI_SENSE_FALL 2'h2
`define EPI_SENSE_RISE 2'h3
`define EPI_RST_BYTE 8'h00
`define EPI_RST_BIT 1'h0
`define EPI_RST_WORD 32'h00000000

`endif

//--- rtl/epi_unit.v
`timescale 1ns/1ns
`default_nettype none
`include "epi_regs.vh"

module epi_unit (
  // Clock, reset, enable
  input wire core_clk,
  input wire rst,
  input wire clk_en,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Interrupt pins
  input wire ext_line_zero,
  input wire ext_line_one,
  input wire ext_line_two,
  // Sleep input buffer control
  input wire sleep_active,
  // Requests to the core, one per vector
  output reg line_zero_req_q,
  output reg line_one_req_q,
  output reg line_two_req_q
);

  // ****************************************
  // Registers
  // ****************************************
  reg [7:0] enable_q;
  reg [7:0] mcu_ctl_q;
  reg [7:0] mcu_cs_q;
  reg [7:0] cpu_stat_q;
  reg line_zero_flag_q;
  reg line_one_flag_q;
  reg line_two_flag_q;
  reg buf_off_q;
  reg two_sync1_q;
  reg two_sync2_q;
  reg two_prev_q;
  reg [31:0] rd_d;

  wire wr_acc;
  wire rd_acc;
  wire ev_zero;
  wire ev_one;
  wire lvl_zero;
  wire lvl_one;
  wire global_en;
  wire zero_is_level;
  wire one_is_level;
  wire two_int;
  wire two_ev;
  wire clr_zero;
  wire clr_one;
  wire clr_two;
  wire [1:0] zero_sense;
  wire [1:0] one_sense;
  wire hit;

  function is_byte_reg;
    input [11:0] a;
    begin
      is_byte_reg = (a == `EPI_ADDR_ENABLE) || (a == `EPI_ADDR_FLAG) ||
        (a == `EPI_ADDR_MCUCTL) || (a == `EPI_ADDR_MCUCS) ||
        (a == `EPI_ADDR_CPUSTAT) || (a == `EPI_ADDR_ACK);
    end
  endfunction

  assign wr_acc = psel & penable & pwrite & clk_en;
  assign rd_acc = psel & penable & ~pwrite & clk_en;
  assign hit = is_byte_reg(paddr);

  assign zero_sense = {mcu_ctl_q[`EPI_BIT_ZERO_SENSE_HI],
    mcu_ctl_q[`EPI_BIT_ZERO_SENSE_LO]}; // [RL6]
  assign one_sense = {mcu_ctl_q[`EPI_BIT_ONE_SENSE_HI],
    mcu_ctl_q[`EPI_BIT_ONE_SENSE_LO]}; // [RL2]
  assign zero_is_level = (zero_sense == `EPI_SENSE_LOW);
  assign one_is_level = (one_sense == `EPI_SENSE_LOW);
  assign global_en = cpu_stat_q[`EPI_BIT_GLOBAL];

  // ****************************************
  // Line zero and one detectors
  // ****************************************
  epi_line_detect #(.EDGE_ONLY(0)) u_zero (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .pin(ext_line_zero),
    .sense(zero_sense),
    .event_p(ev_zero),
    .level_low(lvl_zero)
  );

  epi_line_detect #(.EDGE_ONLY(0)) u_one (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .pin(ext_line_one),
    .sense(one_sense),
    .event_p(ev_one),
    .level_low(lvl_one)
  );

  // ****************************************
  // Line two: edge only, buffer gated in sleep while line two is disabled
  // ****************************************
  // Disabled buffer reads low, which may look like a falling edge
  assign two_int = two_sync2_q & ~buf_off_q; // [RL17]
  assign two_ev = mcu_cs_q[`EPI_BIT_TWO_EDGE] ? (~two_prev_q & two_int) :
    (two_prev_q & ~two_int); // [RL8] [RL19]

  always @(posedge core_clk) begin
    if (rst) begin
      two_sync1_q <= 1'h1;
      two_sync2_q <= 1'h1;
      two_prev_q <= 1'h1;
      buf_off_q <= `EPI_RST_BIT;
    end else if (clk_en) begin
      two_sync1_q <= ext_line_two; // [RL22] [RL3]
      two_sync2_q <= two_sync1_q;
      two_prev_q <= two_int;
      buf_off_q <= sleep_active & ~enable_q[`EPI_BIT_LINE_TWO]; // [RL17]
    end
  end

  // ****************************************
  // Flag clears: vector entry or write of one
  // ****************************************
  assign clr_zero = wr_acc && ((paddr == `EPI_ADDR_FLAG) && pwdata[`EPI_BIT_LINE_ZERO] ||
    (paddr == `EPI_ADDR_ACK) && pwdata[`EPI_BIT_LINE_ZERO]); // [RL13] [RL14]
  assign clr_one = wr_acc && ((paddr == `EPI_ADDR_FLAG) && pwdata[`EPI_BIT_LINE_ONE] ||
    (paddr == `EPI_ADDR_ACK) && pwdata[`EPI_BIT_LINE_ONE]); // [RL13] [RL14]
  assign clr_two = wr_acc && ((paddr == `EPI_ADDR_FLAG) && pwdata[`EPI_BIT_LINE_TWO] ||
    (paddr == `EPI_ADDR_ACK) && pwdata[`EPI_BIT_LINE_TWO]); // [RL13] [RL14]

  // ****************************************
  // Registers and flags
  // ****************************************
  always @(posedge core_clk) begin
    if (rst) begin
      enable_q <= `EPI_RST_BYTE;
      mcu_ctl_q <= `EPI_RST_BYTE;
      mcu_cs_q <= `EPI_RST_BYTE;
      cpu_stat_q <= `EPI_RST_BYTE;
      line_zero_flag_q <= `EPI_RST_BIT;
      line_one_flag_q <= `EPI_RST_BIT;
      line_two_flag_q <= `EPI_RST_BIT;
    end else if (clk_en) begin
      if (wr_acc && paddr == `EPI_ADDR_ENABLE) begin
        enable_q <= pwdata[7:0];
      end
      if (wr_acc && paddr == `EPI_ADDR_MCUCTL) begin
        mcu_ctl_q <= pwdata[7:0];
      end
      if (wr_acc && paddr == `EPI_ADDR_MCUCS) begin
        mcu_cs_q <= pwdata[7:0];
      end
      if (wr_acc && paddr == `EPI_ADDR_CPUSTAT) begin
        cpu_stat_q <= pwdata[7:0];
      end
      // Set wins over clear in the same cycle
      if (zero_is_level) begin
        line_zero_flag_q <= 1'h0; // [RL16]
      end else if (ev_zero) begin
        line_zero_flag_q <= 1'h1; // [RL10]
      end else if (clr_zero) begin
        line_zero_flag_q <= 1'h0;
      end
      if (one_is_level) begin
        line_one_flag_q <= 1'h0; // [RL15]
      end else if (ev_one) begin
        line_one_flag_q <= 1'h1; // [RL9]
      end else if (clr_one) begin
        line_one_flag_q <= 1'h0;
      end
      if (two_ev) begin
        line_two_flag_q <= 1'h1; // [RL11]
      end else if (clr_two) begin
        line_two_flag_q <= 1'h0;
      end
    end
  end

  // ****************************************
  // Requests to the core
  // ****************************************
  always @(posedge core_clk) begin
    if (rst) begin
      line_zero_req_q <= `EPI_RST_BIT;
      line_one_req_q <= `EPI_RST_BIT;
      line_two_req_q <= `EPI_RST_BIT;
    end else if (clk_en) begin
      line_zero_req_q <= global_en & enable_q[`EPI_BIT_LINE_ZERO] &
        (line_zero_flag_q | lvl_zero); // [RL5] [RL12] [RL21] [RL4]
      line_one_req_q <= global_en & enable_q[`EPI_BIT_LINE_ONE] &
        (line_one_flag_q | lvl_one); // [RL1] [RL12] [RL21] [RL4]
      line_two_req_q <= global_en & enable_q[`EPI_BIT_LINE_TWO] &
        line_two_flag_q; // [RL7] [RL12] [RL4]
    end
  end

  // ****************************************
  // APB read and response
  // ****************************************
  always @* begin
    rd_d = `EPI_RST_WORD;
    case (paddr)
      `EPI_ADDR_ENABLE: rd_d[7:0] = enable_q;
      `EPI_ADDR_FLAG: begin
        rd_d[`EPI_BIT_LINE_ONE] = line_one_flag_q;
        rd_d[`EPI_BIT_LINE_ZERO] = line_zero_flag_q;
        rd_d[`EPI_BIT_LINE_TWO] = line_two_flag_q;
      end
      `EPI_ADDR_MCUCTL: rd_d[7:0] = mcu_ctl_q;
      `EPI_ADDR_MCUCS: rd_d[7:0] = mcu_cs_q;
      `EPI_ADDR_CPUSTAT: rd_d[7:0] = cpu_stat_q;
      default: rd_d = `EPI_RST_WORD;
    endcase
  end

  // No wait state: pready rises at the setup-phase edge, high in the first access cycle
  always @(posedge core_clk) begin
    if (rst) begin
      prdata <= `EPI_RST_WORD;
      pready <= 1'h0;
      pslverr <= 1'h0;
    end else if (clk_en) begin
      if (psel && !penable) begin
        pready <= 1'h1;
        pslverr <= ~hit;
        prdata <= rd_d;
      end else begin
        pready <= 1'h0;
        pslverr <= 1'h0;
      end
    end
  end

endmodule // epi_unit
`default_nettype wire

//--- tb/epi_pin_src.sv
`timescale 1ns/1ns
`default_nettype none
module epi_pin_src (
  // Clock
  input wire logic core_clk,
  // Pins
  output logic ext_line_zero = 1'b1,
  output logic ext_line_one = 1'b1,
  output logic ext_line_two = 1'b1
);
  // Moves all three pins together just after an edge
  task put(input logic [2:0] v);
    @(posedge core_clk);
    {ext_line_two, ext_line_one, ext_line_zero} <= v;
  endtask
endmodule // epi_pin_src
`default_nettype wire

//--- tb/epi_unit_sva.sv
`timescale 1ns/1ns
`default_nettype none
module epi_unit_sva (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Pins and requests
  input wire logic ext_line_zero,
  input wire logic ext_line_one,
  input wire logic ext_line_two,
  input wire logic sleep_active,
  input wire logic line_zero_req_q,
  input wire logic line_one_req_q,
  input wire logic line_two_req_q
);
  // ****************************************
  // Shadow of the settings seen on the bus
  // ****************************************
  logic [7:0] en_q;
  logic [7:0] s_q;
  logic [7:0] cs_q;
  logic gl_q;
  wire wr = psel && penable && pready && pwrite;
  always @(posedge core_clk) begin
    if (rst) begin
      en_q <= 8'h00;
      s_q <= 8'h00;
      cs_q <= 8'h00;
      gl_q <= 1'b0;
    end else if (wr) begin
      case (paddr)
        12'h000: en_q <= pwdata[7:0];
        12'h008: s_q <= pwdata[7:0];
        12'h00C: cs_q <= pwdata[7:0];
        12'h010: gl_q <= pwdata[7];
        default: ;
      endcase
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire c0r = gl_q && en_q[6] && s_q[1:0] == 2'h3 && !psel;
  wire c2f = gl_q && en_q[5] && !cs_q[6] && !sleep_active && !psel;
  wire rd_flag = pready && !pwrite && paddr == 12'h004;
  sequence s_rise0;
    (c0r && !ext_line_zero) ##1 (c0r && ext_line_zero)[*6];
  endsequence
  sequence s_fall2;
    (c2f && ext_line_two) ##1 (c2f && !ext_line_two)[*6];
  endsequence
  AST_RDY: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("access phase length wrong");
  AST_EN1: assert property (line_one_req_q |-> $past(en_q[7] && gl_q))
    else $error("line one request while masked");
  AST_EN0: assert property (line_zero_req_q |-> $past(en_q[6] && gl_q))
    else $error("line zero request while masked");
  AST_EN2: assert property (line_two_req_q |-> $past(en_q[5] && gl_q))
    else $error("line two request while masked");
  AST_RISE0: assert property (s_rise0 |-> line_zero_req_q)
    else $error("line zero rising edge missed");
  AST_FALL2: assert property (s_fall2 |-> line_two_req_q)
    else $error("line two falling edge missed");
  AST_LVL1: assert property ((gl_q && en_q[7] && s_q[3:2] == 2'h0 && !ext_line_one)[*5]
    |-> line_one_req_q) else $error("line one level request missing");
  AST_LVLF: assert property (rd_flag && s_q[1:0] == 2'h0 && $past(s_q[1:0]) == 2'h0
    |-> !prdata[6]) else $error("line zero flag set in level mode");
  AST_ACK: assert property (wr && paddr == 12'h014 && pwdata[7] && s_q[3:2] != 2'h0
    |=> ##1 !line_one_req_q) else $error("vector entry left request");
  AST_W1C: assert property (wr && paddr == 12'h004 && pwdata[6] && s_q[1:0] != 2'h0
    |=> ##1 !line_zero_req_q) else $error("flag write left request");
endmodule // epi_unit_sva
bind epi_unit epi_unit_sva chk_u (.core_clk, .rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .ext_line_zero, .ext_line_one, .ext_line_two,
  .sleep_active, .line_zero_req_q, .line_one_req_q, .line_two_req_q);
`default_nettype wire

//--- tb/test_external_pin_interrupt_unit.sv
`timescale 1ns/1ns
`default_nettype none
module test_external_pin_interrupt_unit;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic sleep_active = 1'b0;
  logic clk_en = 1'b1;
  wire [31:0] prdata;
  wire pready, pslverr, ext_line_zero, ext_line_one, ext_line_two;
  wire line_zero_req_q, line_one_req_q, line_two_req_q;
  int n_errors = 0;
  int checked = 0;
  logic [31:0] rd;
  logic er;
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  epi_unit dut_u (.core_clk, .rst, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ext_line_zero, .ext_line_one, .ext_line_two,
    .sleep_active, .line_zero_req_q, .line_one_req_q, .line_two_req_q);
  epi_pin_src src_u (.core_clk, .ext_line_zero, .ext_line_one, .ext_line_two);
  // ****************************************
  // Tasks
  // ****************************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Waits for the answer; only the watchdog ends a hang
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task settle;
    repeat (6) @(posedge core_clk);
  endtask
  task reqs(input logic [2:0] exp);
    #1;
    chk({29'h0, line_two_req_q, line_one_req_q, line_zero_req_q}, {29'h0, exp});
  endtask
  task close_out;
    if (n_errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    close_out;
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    logic s;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    for (int a = 0; a < 6; a++) rdc(12'(a * 4), 32'h0);
    rdc(12'h018, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, 12'h010, 32'h80);
    apb(1'b1, 12'h000, 32'hE0);
    rdc(12'h000, 32'hE0);
    for (int m = 1; m < 4; m++) begin
      s = (m == 3);
      apb(1'b1, 12'h008, {28'h0, m[1:0], m[1:0]});
      apb(1'b1, 12'h00C, {25'h0, s, 6'h00});
      src_u.put({3{s}});
      settle;
      apb(1'b1, 12'h004, 32'hE0);
      src_u.put({3{!s}});
      settle;
      rdc(12'h004, (m == 1) ? 32'hC0 : 32'h00);
      apb(1'b1, 12'h004, 32'hE0);
      src_u.put({3{s}});
      settle;
      rdc(12'h004, 32'hE0);
    end
    reqs(3'h7);
    apb(1'b1, 12'h010, 32'h0);
    settle;
    reqs(3'h0);
    apb(1'b1, 12'h010, 32'h80);
    apb(1'b1, 12'h000, 32'hA0);
    settle;
    reqs(3'h6);
    apb(1'b1, 12'h000, 32'hE0);
    apb(1'b1, 12'h014, 32'h80);
    settle;
    rdc(12'h004, 32'h60);
    reqs(3'h5);
    apb(1'b1, 12'h004, 32'h0);
    rdc(12'h004, 32'h60);
    apb(1'b1, 12'h004, 32'h40);
    rdc(12'h004, 32'h20);
    apb(1'b1, 12'h008, 32'h5);
    src_u.put(3'h4);
    settle;
    rdc(12'h004, 32'hE0);
    // Flags are set here, so level mode must force the line zero and one flags back to zero
    apb(1'b1, 12'h008, 32'h0);
    settle;
    reqs(3'h7);
    rdc(12'h004, 32'h20);
    src_u.put(3'h7);
    settle;
    reqs(3'h4);
    apb(1'b1, 12'h00C, 32'h0);
    apb(1'b1, 12'h000, 32'hC0);
    apb(1'b1, 12'h004, 32'hE0);
    @(posedge core_clk);
    sleep_active <= 1'b1;
    settle;
    rdc(12'h004, 32'h20);
    reqs(3'h0);
    // Clock enable low: pin edges are held off until it returns
    apb(1'b1, 12'h008, 32'h5);
    @(posedge core_clk);
    clk_en <= 1'b0;
    src_u.put(3'h4);
    settle;
    reqs(3'h0);
    @(posedge core_clk);
    clk_en <= 1'b1;
    settle;
    reqs(3'h3);
    close_out;
  end
endmodule // test_external_pin_interrupt_unit
`default_nettype wire
